// [hdl/pinmux_params.svh]
// Offsets, field positions, reset masks and function tables of the pin function select block
`ifndef PINMUX_PARAMS_SVH
`define PINMUX_PARAMS_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define PINS            40
`define PORTS           5
`define PORT_LSB        5
`define REG_LSB         2

// ****************************************************************
// Register index within a port (byte offset = port*0x20 + index*4)
// ****************************************************************
`define IDX_ALT_SEL     3'h0
`define IDX_DIG_EN      3'h1
`define IDX_ANA_MODE    3'h2
`define IDX_PULL_UP     3'h3
`define IDX_PULL_DN     3'h4
`define IDX_PORT_CTL    3'h5
`define IDX_DIG_STAT    3'h6
`define IDX_ANA_STAT    3'h7

// ****************************************************************
// Per-pin tables, pin index = port*8 + bit, 4 bits per pin for selectors
// ****************************************************************
`define PRESENT_MASK    40'h1F0FFFFFFF
`define ISO_ANA_MASK    40'h0F0F000000
`define DIR_ANA_MASK    40'h0000000000
`define RST_ALT_MASK    40'h00000F0C3F
`define RST_DEN_MASK    40'h00000F0C3F
`define RST_PUP_MASK    40'h00000F0000
`define RST_PDN_MASK    40'h0000000000
`define RST_SEL_MAP     160'h0000000000000000000033330000110000111111
`define FUNC_SEL_MAP    160'h0001000000000000111133333110111111111111

`endif

// [hdl/pinmux_pkg.sv]
// Types shared by the pin function select block
package pinmux_pkg;

    typedef struct packed {
        logic       alt;
        logic       digital_enable_bit;
        logic       ams;
        logic       pup;
        logic       pdn;
        logic [3:0] sel;
    } pin_cfg_t;

    typedef struct packed {
        logic dig;
        logic ana;
        logic ien;
        logic pup;
        logic pdn;
        logic oe;
        logic out;
        logic per_in;
        logic gpio_in;
    } pad_drive_t;

    typedef enum logic [2:0] {
        F_ALT = 3'h0,
        F_DEN = 3'h1,
        F_AMS = 3'h2,
        F_PUP = 3'h3,
        F_PDN = 3'h4,
        F_SEL = 3'h5,
        F_RO6 = 3'h6,
        F_RO7 = 3'h7
    } cfg_field_t;

    typedef enum logic {
        BUS_IDLE   = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_t;

endpackage

// [hdl/pin_cell.sv]
// One pin: configuration store, function routing and registered pad drive
`timescale 1ns/1ps
module pin_cell #(
    parameter logic                PRESENT  = 1'b1,
    parameter logic [3:0]          FUNC_SEL = 4'h0,
    parameter logic                ISO_ANA  = 1'b0,
    parameter logic                DIR_ANA  = 1'b0,
    parameter pinmux_pkg::pin_cfg_t RST_CFG = '0
) (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    // Configuration write
    input  wire logic                   wr_i,
    input  wire pinmux_pkg::cfg_field_t field_i,
    input  wire logic                   bit_i,
    input  wire logic [3:0]             sel_i,
    // Function sources and pad
    input  wire logic                   periph_out_i,
    input  wire logic                   periph_oe_i,
    input  wire logic                   gpio_out_i,
    input  wire logic                   gpio_oe_i,
    input  wire logic                   pad_in_i,
    // State
    output pinmux_pkg::pin_cfg_t        cfg_o,
    output pinmux_pkg::pad_drive_t      drive_o
);

    localparam pinmux_pkg::pad_drive_t DRV_RST = '{dig: 1'b0, ana: 1'b0, ien: RST_CFG.digital_enable_bit,
        pup: RST_CFG.pup, pdn: RST_CFG.pdn, oe: 1'b0, out: 1'b0, per_in: 1'b0, gpio_in: 1'b0};

    pinmux_pkg::pin_cfg_t   cfg_r;
    pinmux_pkg::pin_cfg_t   cfg_nxt;
    pinmux_pkg::pad_drive_t drv_r;
    pinmux_pkg::pad_drive_t drv_nxt;
    logic                   fn_hit;
    logic                   dig;

    // Only this pin's strobe touches this store
    always_comb begin
        cfg_nxt = cfg_r;
        if (wr_i && PRESENT) begin // RULE_05
            case (field_i)
                pinmux_pkg::F_ALT: cfg_nxt.alt = bit_i;
                pinmux_pkg::F_DEN: cfg_nxt.digital_enable_bit = bit_i;
                pinmux_pkg::F_AMS: cfg_nxt.ams = bit_i;
                pinmux_pkg::F_PUP: cfg_nxt.pup = bit_i;
                pinmux_pkg::F_PDN: cfg_nxt.pdn = bit_i;
                pinmux_pkg::F_SEL: cfg_nxt.sel = sel_i; // RULE_04
                default:           cfg_nxt     = cfg_r;
            endcase
        end
    end

    always_comb begin
        fn_hit          = PRESENT && (FUNC_SEL != 4'h0) && (cfg_r.sel == FUNC_SEL); // RULE_10
        dig             = cfg_r.alt && cfg_r.digital_enable_bit && fn_hit; // RULE_03
        drv_nxt.dig     = dig;
        drv_nxt.ana     = PRESENT && !cfg_r.digital_enable_bit && (ISO_ANA ? cfg_r.ams : DIR_ANA); // RULE_01
        drv_nxt.ien     = cfg_r.digital_enable_bit;
        drv_nxt.pup     = cfg_r.pup;
        drv_nxt.pdn     = cfg_r.pdn;
        // Alternate mode with an unassigned selector leaves the pad undriven
        drv_nxt.out     = dig ? periph_out_i : (!cfg_r.alt && PRESENT && gpio_out_i);
        drv_nxt.oe      = dig ? periph_oe_i : (!cfg_r.alt && PRESENT && gpio_oe_i);
        drv_nxt.per_in  = dig && pad_in_i; // RULE_03
        drv_nxt.gpio_in = cfg_r.digital_enable_bit && !cfg_r.alt && pad_in_i;
    end

    // Reset overrides the clock enable so a pin never wakes in a stale mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r <= RST_CFG; // RULE_07
            drv_r <= DRV_RST;
        end else if (ce_i) begin
            cfg_r <= cfg_nxt;
            drv_r <= drv_nxt;
        end
    end

    assign cfg_o   = cfg_r;
    assign drive_o = drv_r;

    chk_iso_analog_on: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
        ce_i && PRESENT && ISO_ANA && !cfg_r.digital_enable_bit && cfg_r.ams |=> drv_r.ana)
        else $error("isolated analog path not opened");
    chk_direct_analog_on: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
        ce_i && PRESENT && DIR_ANA && !cfg_r.digital_enable_bit |=> drv_r.ana)
        else $error("direct analog path not opened");
    chk_analog_needs_off: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
        ce_i && cfg_r.digital_enable_bit |=> !drv_r.ana)
        else $error("analog path open with digital enable set");
    chk_periph_gate: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
        ce_i && !(cfg_r.alt && cfg_r.digital_enable_bit) |=> !drv_r.dig && !drv_r.per_in)
        else $error("peripheral connected without alternate and digital enable");
    chk_sel_connect: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
        ce_i && cfg_r.alt && cfg_r.digital_enable_bit |=> drv_r.dig == $past(fn_hit)
            && (!drv_r.dig || drv_r.oe == $past(periph_oe_i)))
        else $error("selector did not pick the assigned function");
    chk_write_local: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
        !wr_i |=> cfg_r == $past(cfg_r))
        else $error("pin configuration changed without its own strobe");
    chk_reset_value: assert property (@(posedge clk_i) // RULE_06
        rst_i |=> cfg_r == RST_CFG)
        else $error("pin configuration not at default after reset");

endmodule // pin_cell

// [hdl/gpio_pin_function_select.sv]
// Pin function select for five ports: register slave, per-pin routing cells and pad drive
//
// Behaviour
// [RULE_01] An isolated analog pin reaches its converter only with digital enable clear and analog mode set.
// [RULE_02] A directly wired analog pin is handed to its analog function whenever digital enable is clear.
// [RULE_03] A peripheral drives or samples a pin only when alternate select and digital enable are both set.
// [RULE_04] Each pin owns a four-bit selector in its port control word that picks the peripheral signal.
// [RULE_05] Every pin is configured on its own and a write to one pin leaves all others as they were.
// [RULE_06] After reset an ordinary pin is plain tri-stated I/O with every configuration bit and selector zero.
// [RULE_07] Reset returns every configuration bit and selector of every pin to its default value.
// [RULE_08] Port A bits 5:0 and port B bits 3:2 reset to alternate, digitally enabled, no pulls, selector 1.
// [RULE_09] Port C bits 3:0 reset to the debug function with alternate, digital enable, pull-up and selector 3.
// [RULE_10] A selector connects only the signal assigned to that pin; unassigned values connect nothing.
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "pinmux_params.svh"
module gpio_pin_function_select (
    // Clock, reset, enable
    input  wire logic        MCLK_I,
    input  wire logic        RESET_I,
    input  wire logic        CLK_EN_I,
    // Avalon-MM register slave
    input  wire logic [7:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    output logic      [31:0] AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    // Peripheral side, one lane per pin
    input  wire logic [39:0] PERIPH_OUT_I,
    input  wire logic [39:0] PERIPH_OE_I,
    output logic      [39:0] PERIPH_IN_O,
    output logic      [39:0] ANALOG_EN_O,
    // Software I/O side
    input  wire logic [39:0] GPIO_OUT_I,
    input  wire logic [39:0] GPIO_OE_I,
    output logic      [39:0] GPIO_IN_O,
    // Pads
    input  wire logic [39:0] PAD_IN_I,
    output logic      [39:0] PAD_OUT_O,
    output logic      [39:0] PAD_OE_O,
    output logic      [39:0] PAD_PULLUP_O,
    output logic      [39:0] PAD_PULLDN_O,
    output logic      [39:0] PAD_INEN_O
);

    // ****************************************************************
    // Tables
    // ****************************************************************
    localparam logic [39:0]  PRESENT  = `PRESENT_MASK;
    localparam logic [39:0]  ISO_ANA  = `ISO_ANA_MASK;
    localparam logic [39:0]  DIR_ANA  = `DIR_ANA_MASK;
    localparam logic [39:0]  RST_ALT  = `RST_ALT_MASK;
    localparam logic [39:0]  RST_DEN  = `RST_DEN_MASK;
    localparam logic [39:0]  RST_PUP  = `RST_PUP_MASK;
    localparam logic [39:0]  RST_PDN  = `RST_PDN_MASK;
    localparam logic [159:0] RST_SEL  = `RST_SEL_MAP;
    localparam logic [159:0] FUNC_MAP = `FUNC_SEL_MAP;
    localparam logic [2:0]   NPORTS   = 3'(`PORTS);

    // ****************************************************************
    // Bus slave state
    // ****************************************************************
    pinmux_pkg::bus_state_t state_r;
    pinmux_pkg::bus_state_t state_nxt;
    logic                   wait_r;
    logic                   wait_nxt;
    logic [31:0]            rdata_r;
    logic [31:0]            rdata_nxt;

    logic [2:0]             port;
    pinmux_pkg::cfg_field_t field;
    logic                   mapped;
    logic                   req;
    logic                   wr_take;
    logic [31:0]            rd_val;

    // Per-pin state gathered back into vectors spanning all five ports
    logic [39:0]            alt_v;
    logic [39:0]            den_v;
    logic [39:0]            ams_v;
    logic [39:0]            pup_v;
    logic [39:0]            pdn_v;
    logic [159:0]           sel_v;
    logic [39:0]            dig_v;
    logic [39:0]            ana_v;
    logic [39:0]            pin_wr;
    logic [159:0]           sel_pres;

    assign port    = AVS_ADDRESS_I[7:`PORT_LSB];
    assign field   = pinmux_pkg::cfg_field_t'(AVS_ADDRESS_I[`PORT_LSB-1:`REG_LSB]);
    assign mapped  = (port < NPORTS) && (AVS_ADDRESS_I[1:0] == 2'h0);
    assign req     = AVS_READ_I || AVS_WRITE_I;
    // A write lands on the edge where the master sees waitrequest low
    assign wr_take = CLK_EN_I && (state_r == pinmux_pkg::BUS_ANSWER) && AVS_WRITE_I && mapped;

    // ****************************************************************
    // Read data select
    // ****************************************************************
    always_comb begin
        rd_val = 32'h0000_0000;
        if (mapped) begin
            case (field)
                pinmux_pkg::F_ALT: rd_val = {24'h00_0000, alt_v[{port, 3'h0} +: 8]};
                pinmux_pkg::F_DEN: rd_val = {24'h00_0000, den_v[{port, 3'h0} +: 8]};
                pinmux_pkg::F_AMS: rd_val = {24'h00_0000, ams_v[{port, 3'h0} +: 8]};
                pinmux_pkg::F_PUP: rd_val = {24'h00_0000, pup_v[{port, 3'h0} +: 8]};
                pinmux_pkg::F_PDN: rd_val = {24'h00_0000, pdn_v[{port, 3'h0} +: 8]};
                pinmux_pkg::F_SEL: rd_val = sel_v[{port, 5'h00} +: 32]; // RULE_04
                pinmux_pkg::F_RO6: rd_val = {24'h00_0000, dig_v[{port, 3'h0} +: 8]};
                pinmux_pkg::F_RO7: rd_val = {24'h00_0000, ana_v[{port, 3'h0} +: 8]};
                default:           rd_val = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Handshake: one wait cycle, then a single low cycle per request
    // ****************************************************************
    always_comb begin
        state_nxt = state_r;
        wait_nxt  = wait_r;
        rdata_nxt = rdata_r;
        case (state_r)
            pinmux_pkg::BUS_IDLE: begin
                if (req) begin
                    state_nxt = pinmux_pkg::BUS_ANSWER;
                    wait_nxt  = 1'b0;
                    rdata_nxt = AVS_READ_I ? rd_val : 32'h0000_0000;
                end
            end
            pinmux_pkg::BUS_ANSWER: begin
                state_nxt = pinmux_pkg::BUS_IDLE;
                wait_nxt  = 1'b1;
            end
            default: begin
                state_nxt = pinmux_pkg::BUS_IDLE;
                wait_nxt  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            state_r <= pinmux_pkg::BUS_IDLE;
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else if (CLK_EN_I) begin
            state_r <= state_nxt;
            wait_r  <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign AVS_WAITREQUEST_O = wait_r;
    assign AVS_READDATA_O    = rdata_r;

    // ****************************************************************
    // Pin cells
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < `PINS; g = g + 1) begin : g_pin
            localparam int P = g / 8;
            localparam int B = g % 8;
            localparam pinmux_pkg::pin_cfg_t RST_CFG = '{alt: RST_ALT[g], digital_enable_bit: RST_DEN[g],
                ams: 1'b0, pup: RST_PUP[g], pdn: RST_PDN[g], sel: RST_SEL[4*g +: 4]}; // RULE_06 RULE_08 RULE_09
            pinmux_pkg::pin_cfg_t   cfg;
            pinmux_pkg::pad_drive_t drv;

            // Byte lanes: one-byte registers use lane 0, selectors the lane of their nibble
            assign pin_wr[g] = wr_take && (port == 3'(P)) &&
                ((field == pinmux_pkg::F_SEL) ? AVS_BYTEENABLE_I[B/2] : AVS_BYTEENABLE_I[0]); // RULE_05

            pin_cell #(
                .PRESENT  (PRESENT[g]),
                .FUNC_SEL (FUNC_MAP[4*g +: 4]),
                .ISO_ANA  (ISO_ANA[g]),
                .DIR_ANA  (DIR_ANA[g]),
                .RST_CFG  (RST_CFG)
            ) u_cell (
                .clk_i        (MCLK_I),
                .rst_i        (RESET_I),
                .ce_i         (CLK_EN_I),
                .wr_i         (pin_wr[g]),
                .field_i      (field),
                .bit_i        (AVS_WRITEDATA_I[B]),
                .sel_i        (AVS_WRITEDATA_I[4*B +: 4]),
                .periph_out_i (PERIPH_OUT_I[g]),
                .periph_oe_i  (PERIPH_OE_I[g]),
                .gpio_out_i   (GPIO_OUT_I[g]),
                .gpio_oe_i    (GPIO_OE_I[g]),
                .pad_in_i     (PAD_IN_I[g]),
                .cfg_o        (cfg),
                .drive_o      (drv)
            );

            assign alt_v[g]          = cfg.alt;
            assign den_v[g]          = cfg.digital_enable_bit;
            assign ams_v[g]          = cfg.ams;
            assign pup_v[g]          = cfg.pup;
            assign pdn_v[g]          = cfg.pdn;
            assign sel_v[4*g +: 4]   = cfg.sel;
            assign sel_pres[4*g +: 4] = {4{PRESENT[g]}};
            assign dig_v[g]          = drv.dig;
            assign ana_v[g]          = drv.ana;
            assign PAD_OUT_O[g]      = drv.out;
            assign PAD_OE_O[g]       = drv.oe;
            assign PAD_PULLUP_O[g]   = drv.pup;
            assign PAD_PULLDN_O[g]   = drv.pdn;
            assign PAD_INEN_O[g]     = drv.ien;
            assign ANALOG_EN_O[g]    = drv.ana; // RULE_02
            assign PERIPH_IN_O[g]    = drv.per_in;
            assign GPIO_IN_O[g]      = drv.gpio_in;
        end
    endgenerate

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_req_accepted;
        CLK_EN_I && req && wait_r && (state_r == pinmux_pkg::BUS_IDLE);
    endsequence

    sequence s_answer_cycle;
        !AVS_WAITREQUEST_O ##1 (AVS_WAITREQUEST_O || !CLK_EN_I);
    endsequence

    chk_bus_answer: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        s_req_accepted |=> s_answer_cycle)
        else $error("waitrequest did not fall for exactly one cycle");

    chk_unmapped_zero: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        s_req_accepted and (AVS_READ_I && !mapped) |=> AVS_READDATA_O == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");

    chk_sel_readback: assert property (@(posedge MCLK_I) disable iff (RESET_I) // RULE_04
        wr_take && (field == pinmux_pkg::F_SEL) && (AVS_BYTEENABLE_I == 4'hF)
        |=> sel_v[{$past(port), 5'h00} +: 32]
            == ($past(AVS_WRITEDATA_I) & sel_pres[{$past(port), 5'h00} +: 32]))
        else $error("selector word not stored as written");

    chk_other_port_kept: assert property (@(posedge MCLK_I) disable iff (RESET_I) // RULE_05
        wr_take && (port == 3'h0) |=> alt_v[39:8] == $past(alt_v[39:8])
            && sel_v[159:32] == $past(sel_v[159:32]))
        else $error("write to one port disturbed another");

    chk_reset_defaults: assert property (@(posedge MCLK_I) // RULE_06
        RESET_I |=> (alt_v == RST_ALT) && (den_v == RST_DEN) && (ams_v == 40'h00_0000_0000)
            && (pup_v == RST_PUP) && (pdn_v == RST_PDN) && (sel_v == RST_SEL))
        else $error("pin defaults not restored by reset");

    chk_debug_default: assert property (@(posedge MCLK_I) // RULE_09
        RESET_I ##1 RESET_I |=> (sel_v[79:64] == 16'h3333) && (pup_v[19:16] == 4'hF)
            && PAD_PULLUP_O[19:16] == 4'hF)
        else $error("debug pins not in debug function after reset");

    chk_serial_default: assert property (@(posedge MCLK_I) // RULE_08
        RESET_I |=> (sel_v[23:0] == 24'h11_1111) && (sel_v[47:40] == 8'h11)
            && (alt_v[5:0] == 6'h3F) && (den_v[11:10] == 2'h3) && (pup_v[5:0] == 6'h00))
        else $error("serial pins not in their default function after reset");

    chk_no_drive_unassigned: assert property (@(posedge MCLK_I) disable iff (RESET_I) // RULE_10
        CLK_EN_I && alt_v[12] |=> !PAD_OE_O[12] && !PERIPH_IN_O[12])
        else $error("pin with no assigned function was connected");

endmodule // gpio_pin_function_select

// [verification/pad_model.sv]
// Pad model: resolves every pad level from drive, pulls and a floating pattern
`timescale 1ns/1ps
module pad_model (
    // Clock
    input  wire logic        clk_i,
    // Pad controls
    input  wire logic [39:0] out_i,
    input  wire logic [39:0] oe_i,
    input  wire logic [39:0] pu_i,
    input  wire logic [39:0] pd_i,
    // Pad level
    output logic      [39:0] lvl_o
);
    // Undriven pads with no pull flip every cycle, so a stale level never looks driven
    logic [39:0] flt_r = 40'h0;
    logic [39:0] flt_nxt;
    always_comb flt_nxt = ~flt_r;
    always_ff @(posedge clk_i) begin
        flt_r <= flt_nxt;
    end
    assign lvl_o = (oe_i & out_i) | (~oe_i & pu_i) | (~oe_i & ~pu_i & ~pd_i & flt_r);
endmodule // pad_model

// [verification/tb_gpio_pin_function_select.sv]
// Self-checking bench of the pin function select block
`timescale 1ns/1ps
module tb_gpio_pin_function_select;
    // ********************
    // Stimulus and model
    // ********************
    logic         mclk = 1'b0;
    logic         reset = 1'b1;
    logic [7:0]   adr = 8'h00;
    logic         rd = 1'b0;
    logic         wr = 1'b0;
    logic [31:0]  wdat = 32'h0;
    logic [31:0]  rdat, got;
    logic         wreq;
    logic [39:0]  p_out = '0, p_oe = '0, g_out = '0, g_oe = '0;
    logic [39:0]  pad, p_in, a_en, g_in, o_lv, o_en, o_pu, o_pd, o_ie;
    logic [39:0]  alt, digital_enable_bit, ams, pup, pdn;
    logic [159:0] sel;
    logic [31:0]  rnd = 32'h675FB8FD;
    int           n_errors = 0;
    int           check_count = 0;
    always #5 mclk = ~mclk;
    gpio_pin_function_select i_gpio_pin_function_select (
        .MCLK_I(mclk), .RESET_I(reset), .CLK_EN_I(1'b1), .AVS_ADDRESS_I(adr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(4'hF),
        .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
        .PERIPH_OUT_I(p_out), .PERIPH_OE_I(p_oe), .PERIPH_IN_O(p_in),
        .ANALOG_EN_O(a_en), .GPIO_OUT_I(g_out), .GPIO_OE_I(g_oe), .GPIO_IN_O(g_in),
        .PAD_IN_I(pad), .PAD_OUT_O(o_lv), .PAD_OE_O(o_en), .PAD_PULLUP_O(o_pu),
        .PAD_PULLDN_O(o_pd), .PAD_INEN_O(o_ie));
    pad_model i_pad_model (.clk_i(mclk), .out_i(o_lv), .oe_i(o_en), .pu_i(o_pu),
        .pd_i(o_pd), .lvl_o(pad));
    function automatic logic [31:0] rn();
        rnd = {rnd[30:0], 1'b0} ^ (rnd[31] ? 32'h04C11DB7 : 32'h00000000);
        return rnd;
    endfunction
    function automatic logic [39:0] rw();
        logic [63:0] v;
        v = {rn(), rn()};
        return v[39:0];
    endfunction
    function automatic logic prs(input int p);
        return p < 28 || (p > 31 && p < 37);
    endfunction
    function automatic logic iso(input int p);
        return (p > 23 && p < 28) || (p > 31 && p < 36);
    endfunction
    function automatic logic [3:0] asg(input int p);
        if (p > 14 && p < 20) return 4'h3;
        if ((p < 15 && p != 12) || (p > 19 && p < 24) || p == 36) return 4'h1;
        return 4'h0;
    endfunction
    function automatic logic conn(input int p);
        return alt[p] & digital_enable_bit[p] & (asg(p) != 4'h0) & (sel[4*p+:4] === asg(p));
    endfunction
    function automatic logic [31:0] xreg(input int pt, input int ix);
        logic [31:0] v;
        int p;
        v = '0;
        for (int b = 0; b < 8; b++) begin
            p = pt * 8 + b;
            case (ix)
                0: v[b] = alt[p];
                1: v[b] = digital_enable_bit[p];
                2: v[b] = ams[p];
                3: v[b] = pup[p];
                4: v[b] = pdn[p];
                5: v[4*b+:4] = sel[4*p+:4];
                6: v[b] = conn(p);
                default: v[b] = iso(p) & !digital_enable_bit[p] & ams[p];
            endcase
        end
        return v;
    endfunction
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] s);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        // Look between edges so the handshake is seen settled, then act on the edge
        do begin
            @(negedge mclk);
            k++;
        end while (wreq !== 1'b0 && k < 20);
        got = rdat;
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b0;
        if (k >= 20) begin
            n_errors++;
            give_verdict();
        end
    endtask
    task automatic put(input int pt, input int ix, input logic [31:0] d);
        int p;
        bus(1'b1, 8'(pt * 32 + ix * 4), d);
        for (int b = 0; b < 8; b++) begin
            p = pt * 8 + b;
            if (prs(p)) case (ix)
                0: alt[p] = d[b];
                1: digital_enable_bit[p] = d[b];
                2: ams[p] = d[b];
                3: pup[p] = d[b];
                4: pdn[p] = d[b];
                5: sel[4*p+:4] = d[4*b+:4];
                default: ;
            endcase
        end
    endtask
    task automatic defaults();
        alt = 40'h00000F0C3F;
        digital_enable_bit = alt;
        pup = 40'h00000F0000;
        pdn = '0;
        ams = '0;
        sel = {64'h0, 32'h00003333, 32'h00001100, 32'h00111111};
    endtask
    task automatic check_regs();
        for (int pt = 0; pt < 5; pt++) for (int ix = 0; ix < 8; ix++) begin
            bus(1'b0, 8'(pt * 32 + ix * 4), 32'h0);
            chk("register", 40'(xreg(pt, ix)), 40'(got));
        end
    endtask
    task automatic check_pads();
        logic [39:0] c, eoe, ean, eout, m;
        for (int p = 0; p < 40; p++) begin
            c[p] = conn(p);
            eoe[p] = c[p] ? p_oe[p] : (prs(p) & !alt[p] & g_oe[p]);
            eout[p] = c[p] ? p_out[p] : (prs(p) & !alt[p] & g_out[p]);
            ean[p] = iso(p) & !digital_enable_bit[p] & ams[p];
        end
        m = digital_enable_bit & ~alt & g_oe;
        chk("pad_oe", eoe, o_en);
        chk("pad_out", eoe & eout, o_lv & eoe);
        chk("periph_in", c & p_oe & p_out, p_in & ~(c & ~p_oe));
        chk("analog_en", ean, a_en);
        chk("gpio_in", m & g_out, g_in & (m | ~(digital_enable_bit & ~alt)));
        chk("pull_up", pup, o_pu);
        chk("pull_dn", pdn, o_pd);
        chk("in_en", digital_enable_bit, o_ie);
    endtask
    initial begin
        int pt;
        logic [31:0] mw;
        defaults();
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        check_pads();
        check_regs();
        for (int i = 0; i < 48; i++) begin
            pt = int'(rn() % 32'd5);
            for (int b = 0; b < 8; b++) mw[4*b+:4] = asg(pt * 8 + b);
            for (int ix = 0; ix < 6; ix++) put(pt, ix, (ix == 5 && i[0]) ? mw : rn());
            @(posedge mclk);
            p_out <= rw();
            p_oe <= rw();
            g_out <= rw();
            g_oe <= rw();
            repeat (3) @(posedge mclk);
            check_pads();
            check_regs();
        end
        // Status and misaligned writes must be dropped, unmapped reads give zero
        put(0, 6, 32'hFFFFFFFF);
        bus(1'b1, 8'h01, 32'hFFFFFFFF);
        bus(1'b0, 8'hA0, 32'h0);
        chk("unmapped", 40'h0, 40'(got));
        check_regs();
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        defaults();
        check_regs();
        check_pads();
        give_verdict();
    end
endmodule // tb_gpio_pin_function_select
